// ---- logic/eeprom_write_pkg.sv ----
// package: opcodes, status layout, protection codes and shared types of the write sequencer
package eeprom_write_pkg;
	// ------------------------------------------------------------
	// opcodes (upper nibble zero, bit 3 is the ninth address bit)
	// ------------------------------------------------------------
	localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06; // set_write_latch_cmd
	localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04; // clears the latch
	localparam logic [7:0] OP_STATUS_READ = 8'h05; // status_read_cmd
	localparam logic [7:0] OP_MEM_WRITE = 8'h02; // memory write, bit 3 = a8
	localparam logic [7:0] OP_MASK = 8'hF7; // bits compared in an opcode
	localparam int OP_A8_BIT = 3; // ninth address bit inside the opcode
	// ------------------------------------------------------------
	// status byte layout
	// ------------------------------------------------------------
	localparam int ST_BUSY_BIT = 0; // busy_flag
	localparam int ST_LATCH_BIT = 1; // write_enable_latch
	localparam int ST_BP_LO_BIT = 2; // block_protect_lo
	localparam int ST_BP_HI_BIT = 3; // block_protect_hi
	localparam logic [3:0] ST_RFU_IDLE = 4'h0; // bits 7:4 when idle
	localparam logic [3:0] ST_RFU_BUSY = 4'hF; // bits 7:4 during a write cycle
	// ------------------------------------------------------------
	// block protection codes
	// ------------------------------------------------------------
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;
	// ------------------------------------------------------------
	// framing and timing
	// ------------------------------------------------------------
	localparam int BYTE_BITS = 8; // bits per serial byte
	localparam int PAGE_BYTES = 8; // bytes in one row
	localparam int PAGE_BITS = 3; // in-page address width
	localparam int WRITE_CYCLE_TIME_US = 5000; // write_cycle_time, most
	localparam int CLK_PERIOD_NS = 50; // system clock period
	localparam int WRITE_CYCLE_CNT = WRITE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000, // receiving the opcode
		ST_ADDR = 3'b001, // receiving the address byte
		ST_DATA = 3'b010, // receiving data bytes
		ST_STATUS = 3'b011, // shifting status out
		ST_IGNORE = 3'b100 // frame discarded until chip select rises
	} frame_state_e;
	// one byte of the page buffer and its load mark
	typedef struct packed {
		logic loaded;
		logic [7:0] data;
	} page_slot_s;
	// one array write request handed to the array port
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
	} array_wr_s;
endpackage : eeprom_write_pkg

// ---- logic/spi_eeprom_write_sequencer.sv ----
// module: spi eeprom write sequencer, from serial frame to self-timed array write
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_write_sequencer #(
	parameter int ADDR_BITS = 9, // 7, 8 or 9 address bits
	parameter int WRITE_CYCLES = eeprom_write_pkg::WRITE_CYCLE_CNT // cycle length in clocks
) (
	input wire logic clk_sys_in, // system clock, 20 MHz
	input wire logic rst_in, // synchronous reset, active high
	input wire logic cs_n_in, // chip select pin, active low
	input wire logic sck_in, // serial clock pin
	input wire logic si_in, // serial data in pin
	input wire logic wp_n_in, // write protect pin, active low
	input wire logic [1:0] block_protect_in, // protect code {hi, lo}
	output logic so_out, // serial data out
	output logic so_oe_out, // serial out enable, high while driving
	output logic busy_out, // busy_flag
	output logic write_latch_out, // write_enable_latch
	output logic array_we_out, // one-cycle array write strobe
	output var eeprom_write_pkg::array_wr_s array_wr_out // address and data of the strobe
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (ADDR_BITS < 7 || ADDR_BITS > 9) begin : g_bad_addr
		$error("ADDR_BITS must be 7, 8 or 9");
	end
	if (WRITE_CYCLES < 1) begin : g_bad_cyc
		$error("WRITE_CYCLES must be at least 1");
	end
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(WRITE_CYCLES - 1);

	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic [2:0] sync1_ff; // first stage {cs, sck, si}
	logic [2:0] sync2_ff; // second stage
	logic [2:0] sync3_ff; // previous second stage, for edges
	logic wp1_ff; // protect pin first stage
	logic wp2_ff; // protect pin second stage
	logic [2:0] nxt_sync1, nxt_sync2, nxt_sync3;
	logic nxt_wp1, nxt_wp2;

	// next values of the synchroniser chain
	always_comb begin
		nxt_sync1 = {cs_n_in, sck_in, si_in};
		nxt_sync2 = sync1_ff;
		nxt_sync3 = sync2_ff;
		nxt_wp1 = wp_n_in;
		nxt_wp2 = wp1_ff;
	end

	// register the chain; select idles high
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sync1_ff <= 3'h6;
			sync2_ff <= 3'h6;
			sync3_ff <= 3'h6;
			wp1_ff <= 1'b1;
			wp2_ff <= 1'b1;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			sync3_ff <= nxt_sync3;
			wp1_ff <= nxt_wp1;
			wp2_ff <= nxt_wp2;
		end
	end

	wire cs_n = sync2_ff[2]; // synchronised select
	wire sck_rise = sync2_ff[1] & ~sync3_ff[1]; // sample edge
	wire sck_fall = ~sync2_ff[1] & sync3_ff[1]; // shift-out edge
	wire si_bit = sync2_ff[0]; // synchronised data
	wire cs_rise = sync2_ff[2] & ~sync3_ff[2]; // frame end
	wire cs_fall = ~sync2_ff[2] & sync3_ff[2]; // frame start

	// ------------------------------------------------------------
	// frame receiver and write sequencer
	// ------------------------------------------------------------
	eeprom_write_pkg::frame_state_e state_ff, nxt_state;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt; // bit within byte
	logic [7:0] shift_ff, nxt_shift; // incoming byte, msb first
	logic [7:0] so_shift_ff, nxt_so_shift; // outgoing status byte
	logic so_ff, nxt_so;
	logic so_oe_ff, nxt_so_oe;
	logic a8_ff, nxt_a8; // ninth address bit from opcode
	logic [ADDR_BITS-1:0] page_addr_ff, nxt_page_addr; // row base and pointer
	logic [eeprom_write_pkg::PAGE_BITS-1:0] ptr_ff, nxt_ptr; // in-page pointer
	logic pend_set_ff, nxt_pend_set; // latch set on select rise
	logic pend_clr_ff, nxt_pend_clr; // latch clear on select rise
	logic wr_valid_ff, nxt_wr_valid; // a full data byte was loaded
	logic wr_latch_ff, nxt_wr_latch; // write_enable_latch
	logic busy_ff, nxt_busy; // busy_flag
	logic [CNT_W-1:0] cyc_ff, nxt_cyc; // write cycle counter
	logic [eeprom_write_pkg::PAGE_BITS-1:0] drain_ff, nxt_drain; // page slot being committed
	logic we_ff, nxt_we;
	eeprom_write_pkg::array_wr_s wr_ff, nxt_wr;
	eeprom_write_pkg::page_slot_s [eeprom_write_pkg::PAGE_BYTES-1:0] page_ff, nxt_page;
	logic [7:0] rx_byte; // byte completed this cycle
	logic [ADDR_BITS-1:0] base_addr; // addressed location
	logic protected_hit; // base address inside protected range
	logic [8:0] wide_addr;

	// received byte including the bit arriving now
	assign rx_byte = {shift_ff[6:0], si_bit};
	assign wide_addr = 9'(page_addr_ff);

	// protection check against the row base; one row never straddles a range edge
	always_comb begin
		base_addr = page_addr_ff;
		case (block_protect_in)
			eeprom_write_pkg::BP_NONE: protected_hit = 1'b0;
			eeprom_write_pkg::BP_QUARTER: protected_hit = &base_addr[ADDR_BITS-1 -: 2];
			eeprom_write_pkg::BP_HALF: protected_hit = base_addr[ADDR_BITS-1];
			eeprom_write_pkg::BP_ALL: protected_hit = 1'b1;
			default: protected_hit = 1'b1;
		endcase
	end

	// next state of the frame and write logic
	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_so_shift = so_shift_ff;
		nxt_so = so_ff;
		nxt_so_oe = so_oe_ff;
		nxt_a8 = a8_ff;
		nxt_page_addr = page_addr_ff;
		nxt_ptr = ptr_ff;
		nxt_pend_set = pend_set_ff;
		nxt_pend_clr = pend_clr_ff;
		nxt_wr_valid = wr_valid_ff;
		nxt_wr_latch = wr_latch_ff;
		nxt_busy = busy_ff;
		nxt_cyc = cyc_ff;
		nxt_drain = drain_ff;
		nxt_we = 1'b0;
		nxt_wr = wr_ff;
		nxt_page = page_ff;
		if (cs_fall) begin
			// fresh frame: back to ST_OPCODE, clear bit count, pending latch commands and wr_valid_ff
			nxt_state = eeprom_write_pkg::ST_OPCODE;
			nxt_bit_cnt = 3'h0;
			nxt_pend_set = 1'b0;
			nxt_pend_clr = 1'b0;
			nxt_wr_valid = 1'b0;
			// a running cycle still drains the page, so its slots survive a status poll
			for (int i = 0; i < eeprom_write_pkg::PAGE_BYTES; i++) begin
				nxt_page[i].loaded = page_ff[i].loaded & busy_ff;
			end
		end else if (!cs_n && sck_rise) begin
			nxt_shift = rx_byte;
			nxt_bit_cnt = bit_cnt_ff + 3'h1;
			if (bit_cnt_ff == 3'(eeprom_write_pkg::BYTE_BITS - 1)) begin
				case (state_ff)
					eeprom_write_pkg::ST_OPCODE: begin
						if ((rx_byte & eeprom_write_pkg::OP_MASK) == eeprom_write_pkg::OP_STATUS_READ) begin
							nxt_state = eeprom_write_pkg::ST_STATUS;
						end else if (busy_ff) begin
							nxt_state = eeprom_write_pkg::ST_IGNORE;
						end else if ((rx_byte & eeprom_write_pkg::OP_MASK) == eeprom_write_pkg::OP_MEM_WRITE) begin
							nxt_a8 = rx_byte[eeprom_write_pkg::OP_A8_BIT];
							// protect pin low or latch clear discards the frame
							nxt_state = (!wp2_ff || !wr_latch_ff) ? eeprom_write_pkg::ST_IGNORE
								: eeprom_write_pkg::ST_ADDR;
						end else if (rx_byte == eeprom_write_pkg::OP_SET_WRITE_LATCH) begin
							nxt_pend_set = wp2_ff;
							nxt_state = eeprom_write_pkg::ST_IGNORE;
						end else if (rx_byte == eeprom_write_pkg::OP_CLR_WRITE_LATCH) begin
							nxt_pend_clr = 1'b1;
							nxt_state = eeprom_write_pkg::ST_IGNORE;
						end else begin
							nxt_state = eeprom_write_pkg::ST_IGNORE;
						end
					end
					eeprom_write_pkg::ST_ADDR: begin
						// address byte follows the opcode
						nxt_page_addr = ADDR_BITS'({a8_ff, rx_byte});
						nxt_ptr = rx_byte[eeprom_write_pkg::PAGE_BITS-1:0];
						nxt_state = eeprom_write_pkg::ST_DATA;
					end
					eeprom_write_pkg::ST_DATA: begin
						// load the slot, then step only the low bits, wrapping in the row
						nxt_page[ptr_ff].data = rx_byte;
						nxt_page[ptr_ff].loaded = 1'b1;
						nxt_ptr = ptr_ff + 3'h1;
						nxt_wr_valid = 1'b1;
					end
					default: begin
						nxt_state = state_ff;
					end
				endcase
			end
		end else if (!cs_n && sck_fall && state_ff == eeprom_write_pkg::ST_STATUS) begin
			// shift status msb first; first byte loaded here, repeats until select rises
			if (bit_cnt_ff == 3'h0 && !so_oe_ff) begin
				nxt_so_shift = {busy_ff ? eeprom_write_pkg::ST_RFU_BUSY : eeprom_write_pkg::ST_RFU_IDLE,
					block_protect_in, wr_latch_ff, busy_ff};
			end
			nxt_so = nxt_so_shift[7];
			nxt_so_shift = {nxt_so_shift[6:0], nxt_so_shift[7]};
			nxt_so_oe = 1'b1;
		end
		if (cs_rise) begin
			nxt_so_oe = 1'b0;
			nxt_state = eeprom_write_pkg::ST_OPCODE;
			if (pend_set_ff && !busy_ff) begin
				nxt_wr_latch = 1'b1;
			end
			if (pend_clr_ff && !busy_ff) begin
				nxt_wr_latch = 1'b0;
			end
			// only whole frames ending on a byte boundary launch a cycle
			if (state_ff == eeprom_write_pkg::ST_DATA && wr_valid_ff && bit_cnt_ff == 3'h0
				&& wp2_ff && !protected_hit) begin
				nxt_busy = 1'b1;
				nxt_cyc = '0;
				nxt_drain = 3'h0;
			end
		end
		if (busy_ff) begin
			// commit loaded slots one per clock, then time out the cycle
			if (page_ff[drain_ff].loaded) begin
				nxt_we = 1'b1;
				nxt_wr.addr = {wide_addr[8:eeprom_write_pkg::PAGE_BITS], drain_ff};
				nxt_wr.data = page_ff[drain_ff].data;
				nxt_page[drain_ff].loaded = 1'b0;
			end
			nxt_drain = drain_ff + 3'h1;
			nxt_cyc = cyc_ff + CNT_W'(1);
			if (cyc_ff == CYC_LAST) begin
				nxt_busy = 1'b0;
				nxt_wr_latch = 1'b0;
			end
		end
	end

	// register the frame and write state
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_ff <= eeprom_write_pkg::ST_OPCODE;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			so_shift_ff <= 8'h00;
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
			a8_ff <= 1'b0;
			page_addr_ff <= '0;
			ptr_ff <= 3'h0;
			pend_set_ff <= 1'b0;
			pend_clr_ff <= 1'b0;
			wr_valid_ff <= 1'b0;
			wr_latch_ff <= 1'b0;
			busy_ff <= 1'b0;
			cyc_ff <= '0;
			drain_ff <= 3'h0;
			we_ff <= 1'b0;
			wr_ff <= '0;
			page_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			so_shift_ff <= nxt_so_shift;
			so_ff <= nxt_so;
			so_oe_ff <= nxt_so_oe;
			a8_ff <= nxt_a8;
			page_addr_ff <= nxt_page_addr;
			ptr_ff <= nxt_ptr;
			pend_set_ff <= nxt_pend_set;
			pend_clr_ff <= nxt_pend_clr;
			wr_valid_ff <= nxt_wr_valid;
			wr_latch_ff <= nxt_wr_latch;
			busy_ff <= nxt_busy;
			cyc_ff <= nxt_cyc;
			drain_ff <= nxt_drain;
			we_ff <= nxt_we;
			wr_ff <= nxt_wr;
			page_ff <= nxt_page;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flip-flops
	// ------------------------------------------------------------
	assign so_out = so_ff;
	assign so_oe_out = so_oe_ff;
	assign busy_out = busy_ff;
	assign write_latch_out = wr_latch_ff;
	assign array_we_out = we_ff;
	assign array_wr_out = wr_ff;
endmodule : spi_eeprom_write_sequencer
`default_nettype wire

// ---- dv/eeprom_write_sva.sv ----
// assertions on the ports of the spi eeprom write sequencer
`timescale 1ns/1ns
`default_nettype none
module eeprom_write_sva #(
	parameter int ADDR_BITS = 9, // address width
	parameter int WRITE_CYCLES = 20 // write cycle length in clocks
) (
	input wire logic clk_sys_in, // system clock
	input wire logic rst_in, // synchronous reset
	input wire logic cs_n_in, // chip select, active low
	input wire logic sck_in, // serial clock
	input wire logic si_in, // serial data in
	input wire logic wp_n_in, // protect pin, active low
	input wire logic [1:0] block_protect_in, // protect code
	input wire logic so_out, // serial data out
	input wire logic so_oe_out, // serial out enable
	input wire logic busy_out, // busy flag
	input wire logic write_latch_out, // write enable latch
	input wire logic array_we_out, // array write strobe
	input wire eeprom_write_pkg::array_wr_s array_wr_out // strobe payload
);
	logic [31:0] busy_cnt_ff; // clocks spent busy so far
	logic [31:0] nxt_busy_cnt; // next busy count
	logic [1:0] top; // two upper address bits of the strobe
	logic prot; // strobe address lies in the protected range
	// busy length count and protected range decode
	always_comb begin
		nxt_busy_cnt = busy_out ? busy_cnt_ff + 32'h1 : 32'h0;
		top = 2'(array_wr_out.addr >> (ADDR_BITS - 2));
		case (block_protect_in)
			2'h1: prot = (top == 2'h3); // upper quarter
			2'h2: prot = top[1]; // upper half
			2'h3: prot = 1'h1; // whole array
			default: prot = 1'h0; // none
		endcase
	end
	// registers the busy count
	always_ff @(posedge clk_sys_in) begin
		busy_cnt_ff <= rst_in ? 32'h0 : nxt_busy_cnt;
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	property p_busy_len; $fell(busy_out) |-> busy_cnt_ff == WRITE_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_needs_latch; $rose(busy_out) |-> write_latch_out; endproperty
	a_needs_latch: assert property (p_needs_latch) else $error("cycle without latch");
	property p_wp_high; $rose(busy_out) |-> $past(wp_n_in, 3); endproperty
	a_wp_high: assert property (p_wp_high) else $error("cycle with protect pin low");
	property p_after_cs; $rose(busy_out) |-> cs_n_in && $past(cs_n_in, 2); endproperty
	a_after_cs: assert property (p_after_cs) else $error("cycle inside frame");
	property p_latch_clr; $fell(busy_out) |-> !write_latch_out; endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");
	property p_latch_hold; busy_out && $past(busy_out) |-> $stable(write_latch_out); endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("command taken while busy");
	property p_we_in_cycle; array_we_out |-> busy_out && busy_cnt_ff <= 32'd10; endproperty
	a_we_in_cycle: assert property (p_we_in_cycle) else $error("strobe outside cycle");
	property p_we_follows; $rose(busy_out) |-> ##[1:9] array_we_out; endproperty
	a_we_follows: assert property (p_we_follows) else $error("no strobe in cycle");
	property p_not_prot; array_we_out |-> !prot; endproperty
	a_not_prot: assert property (p_not_prot) else $error("protected write");
	property p_latch_set; $rose(write_latch_out) |-> !busy_out && $past(cs_n_in, 2); endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch set early");
	property p_oe_off; cs_n_in [*6] |-> !so_oe_out; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven unselected");
endmodule : eeprom_write_sva
bind spi_eeprom_write_sequencer eeprom_write_sva #(.ADDR_BITS(ADDR_BITS),
	.WRITE_CYCLES(WRITE_CYCLES)) chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.cs_n_in(cs_n_in), .sck_in(sck_in), .si_in(si_in), .wp_n_in(wp_n_in),
	.block_protect_in(block_protect_in), .so_out(so_out), .so_oe_out(so_oe_out),
	.busy_out(busy_out), .write_latch_out(write_latch_out), .array_we_out(array_we_out),
	.array_wr_out(array_wr_out));
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// spi host model in mode 0 or 3: chip select, serial clock and serial data
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	input wire logic clk_in, // bench clock, steps on its fall
	input wire logic so_in, // device serial out
	output logic cs_n_out, // chip select, active low
	output logic sck_out, // serial clock, at the mode's idle level outside frames
	output logic si_out // serial data
);
	logic mode3 = 1'h0; // clock idles high and leads with a fall
	initial begin
		cs_n_out = 1'h1;
		sck_out = 1'h0;
		si_out = 1'h0;
	end
	// one bit: data set in the low phase, taken on the rise, msb first
	task automatic bit_io(input logic b, output logic r);
		if (mode3) sck_out = 1'h0; // mode 3 opens each bit with the fall
		si_out = b;
		repeat (4) @(negedge clk_in);
		r = so_in;
		sck_out = 1'h1;
		repeat (4) @(negedge clk_in);
		if (!mode3) sck_out = 1'h0;
	endtask : bit_io
	// pick mode 0 or 3 between frames; the clock idles at the mode's level
	task automatic set_mode(input logic m);
		mode3 = m;
		sck_out = m;
		repeat (4) @(negedge clk_in);
	endtask : set_mode
	// one frame of its own; select rises with the clock at the mode's idle level after the last bit
	task automatic frame(input logic [7:0] q[$], input bit rd, output logic [7:0] st);
		logic r;
		cs_n_out = 1'h0;
		repeat (4) @(negedge clk_in);
		foreach (q[i]) begin
			for (int k = 7; k >= 0; k--) bit_io(q[i][k], r);
		end
		for (int k = 7; k >= 0 && rd; k--) begin
			bit_io(~si_out, r);
			st[k] = r;
		end
		repeat (2) @(negedge clk_in);
		cs_n_out = 1'h1;
		si_out = ~si_out; // released line shows no stale value
		repeat (6) @(negedge clk_in);
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench of the spi eeprom write sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int WC = 400; // shortened write cycle
	logic clk_sys_in = 1'h0, rst_in = 1'h1, wp_n_in = 1'h1;
	logic cs_n_in, sck_in, si_in, so_out, so_oe_out, busy_out, write_latch_out, array_we_out;
	logic [1:0] block_protect_in = 2'h0;
	eeprom_write_pkg::array_wr_s array_wr_out;
	eeprom_write_pkg::array_wr_s exp_q[$]; // expected array writes, oldest first
	logic [7:0] q[$], pg[8], ld, st;
	logic [8:0] a;
	logic [2:0] s;
	int bad_count = 0, compares = 0, n;
	always #25 clk_sys_in = ~clk_sys_in;
	spi_host_model host (.clk_in(clk_sys_in), .so_in(so_out), .cs_n_out(cs_n_in),
		.sck_out(sck_in), .si_out(si_in));
	spi_eeprom_write_sequencer #(.WRITE_CYCLES(WC)) uut (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .cs_n_in(cs_n_in), .sck_in(sck_in), .si_in(si_in),
		.wp_n_in(wp_n_in), .block_protect_in(block_protect_in), .so_out(so_out),
		.so_oe_out(so_oe_out), .busy_out(busy_out), .write_latch_out(write_latch_out),
		.array_we_out(array_we_out), .array_wr_out(array_wr_out));
	task automatic close_out;
		$display("compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic stat(input logic [7:0] exp); // status read and compare
		host.frame('{eeprom_write_pkg::OP_STATUS_READ}, 1, st);
		check({9'h0, st}, {9'h0, exp});
	endtask : stat
	// each strobe takes the oldest expected write off the queue
	always @(negedge clk_sys_in) begin
		if (array_we_out !== 1'h0) begin
			if (exp_q.size() == 0) check(array_wr_out, 17'h1FFFF);
			else check(array_wr_out, exp_q.pop_front());
		end
	end
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		check(17'h1, 17'h0);
		close_out();
	end
	initial begin
		n = $urandom(41461);
		repeat (6) @(negedge clk_sys_in);
		rst_in = 1'h0;
		repeat (4) @(negedge clk_sys_in);
		stat(8'h00);
		host.frame('{8'h02, 8'h10, 8'h55}, 0, st); // no latch: discarded
		check({16'h0, busy_out}, 17'h0);
		wp_n_in = 1'h0;
		host.frame('{8'h06}, 0, st);
		wp_n_in = 1'h1;
		stat(8'h00);
		host.frame('{8'h06}, 0, st);
		stat(8'h02);
		wp_n_in = 1'h0;
		host.frame('{8'h02, 8'h20, 8'h66}, 0, st);
		wp_n_in = 1'h1;
		stat(8'h02);
		// page write, random row, start and length up to ten bytes
		a = 9'($urandom);
		q = '{eeprom_write_pkg::OP_MEM_WRITE | {4'h0, a[8], 3'h0}, a[7:0]};
		ld = 8'h0;
		n = 1 + $urandom % 10; // lengths past the row end exercise the wrap
		for (int i = 0; i < n; i++) begin
			s = 3'(a[2:0] + 3'(i));
			pg[s] = 8'($urandom);
			ld[s] = 1'h1;
			q.push_back(pg[s]);
		end
		for (int i = 0; i < 8; i++) begin
			if (ld[i]) exp_q.push_back({a[8:3], 3'(i), pg[i]});
		end
		host.frame(q, 0, st);
		host.frame('{8'h04}, 0, st); // clear refused while busy
		stat(8'hF3);
		for (int i = 0; i < 20 && st[0] !== 1'h0; i++) host.frame('{8'h05}, 1, st);
		check({9'h0, st}, 17'h0);
		host.set_mode(1'h1); // mode 3 from here on
		for (int b = 1; b < 4; b++) begin
			block_protect_in = 2'(b);
			host.frame('{8'h06}, 0, st);
			host.frame('{8'h0A, 8'hFF, 8'h5A}, 0, st); // top location
			stat({4'h0, 2'(b), 2'h2});
		end
		block_protect_in = 2'h1;
		exp_q.push_back({9'h17F, 8'hA5});
		host.frame('{8'h0A, 8'h7F, 8'hA5}, 0, st); // just below the quarter
		for (n = 0; n < 1000 && busy_out !== 1'h0; n++) @(negedge clk_sys_in);
		if (n == 1000) check(17'(busy_out), 17'h0);
		stat(8'h04);
		check(17'(exp_q.size()), 17'h0);
		close_out();
	end
endmodule : tb
`default_nettype wire
